// ==== src/dsu_pkg.sv ====
package dsu_pkg;

  typedef enum logic [1:0] {
    DSU_ST_IDLE = 2'h1,
    DSU_ST_EXEC = 2'h2
  } dsu_state_t;

  typedef enum logic [1:0] {
    DSU_OP_NONE   = 2'h0,
    DSU_OP_LSR    = 2'h1,
    DSU_OP_DLEFT  = 2'h2,
    DSU_OP_DRIGHT = 2'h3
  } dsu_op_t;

  typedef enum logic [1:0] {
    DSU_CS_ONE = 2'h0,
    DSU_CS_LOW = 2'h1,
    DSU_CS_IMM = 2'h2
  } dsu_csrc_t;

  typedef enum logic [1:0] {
    DSU_MODE_REAL = 2'h0,
    DSU_MODE_PROT = 2'h1,
    DSU_MODE_V86  = 2'h2
  } dsu_mode_t;

  typedef struct packed {
    dsu_op_t    op;
    logic [5:0] width;
    dsu_csrc_t  csrc;
    logic [2:0] lat;
  } dsu_dec_t;

endpackage : dsu_pkg

// ==== src/dsu_regs.svh ====
`ifndef DSU_REGS_SVH
`define DSU_REGS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define DSU_OFF_CTRL      8'h00
`define DSU_OFF_DEST      8'h04
`define DSU_OFF_FILL      8'h08
`define DSU_OFF_IMM       8'h0c
`define DSU_OFF_CNT_LOW   8'h10
`define DSU_OFF_ADDR      8'h14
`define DSU_OFF_GO        8'h18
`define DSU_OFF_STATUS    8'h1c
`define DSU_OFF_FLAGS     8'h20

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define DSU_CTRL_OPC_HI   7
`define DSU_CTRL_ESC      8
`define DSU_CTRL_REG_HI   11
`define DSU_CTRL_REG_LO   9
`define DSU_CTRL_SIZE32   12
`define DSU_CTRL_MEM      13
`define DSU_CTRL_MODE_HI  15
`define DSU_CTRL_MODE_LO  14
`define DSU_CTRL_CPL_HI   17
`define DSU_CTRL_CPL_LO   16
`define DSU_CTRL_WRITABLE 18
`define DSU_CTRL_LEGAL    19
`define DSU_CTRL_STACK    20
`define DSU_CTRL_PRESENT  21
`define DSU_CTRL_ALIGN_EN 22
`define DSU_CTRL_MASK     32'h007fffff

// ----------------------------------------------------------------
// Status and flag fields, reset values
// ----------------------------------------------------------------
`define DSU_STAT_BUSY     0
`define DSU_STAT_DONE     1
`define DSU_STAT_EXC      2
`define DSU_STAT_BAD_OP   3
`define DSU_STAT_VEC_LO   8
`define DSU_FLAG_CARRY    0
`define DSU_FLAG_PARITY   2
`define DSU_FLAG_AUX      4
`define DSU_FLAG_ZERO     6
`define DSU_FLAG_SIGN     7
`define DSU_FLAG_OVER     11
`define DSU_FLAGS_RESET   12'h002
`define DSU_FLAGS_MASK    12'hfd5

// ----------------------------------------------------------------
// Opcodes, fault vectors, limits
// ----------------------------------------------------------------
`define DSU_OPC_B_ONE     8'hd0
`define DSU_OPC_V_ONE     8'hd1
`define DSU_OPC_B_LOW     8'hd2
`define DSU_OPC_V_LOW     8'hd3
`define DSU_OPC_B_IMM     8'hc0
`define DSU_OPC_V_IMM     8'hc1
`define DSU_OPC_DL_IMM    8'ha4
`define DSU_OPC_DL_LOW    8'ha5
`define DSU_OPC_DR_IMM    8'hac
`define DSU_OPC_DR_LOW    8'had
`define DSU_REG_LSR       3'h5
`define DSU_VEC_GP        5'h0d
`define DSU_VEC_SS        5'h0c
`define DSU_VEC_PAGE      5'h0e
`define DSU_VEC_ALIGN     5'h11
`define DSU_REAL_LIMIT    33'h00000ffff
`define DSU_CPL_USER      2'h3

// ----------------------------------------------------------------
// Execution clocks (register form / memory form)
// ----------------------------------------------------------------
`define DSU_LAT_CNT_REG   3'h3
`define DSU_LAT_CNT_MEM   3'h4
`define DSU_LAT_IMM_REG   3'h2
`define DSU_LAT_LSR_IMM_MEM 3'h4
`define DSU_LAT_DBL_IMM_MEM 3'h3

`endif

// ==== src/dsu_shift_unit.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "dsu_regs.svh"

// Behaviour
// - Double shift count mod 32; zero: nothing changes
// - Count at or above width: any result allowed
// - Left double shift fills from fill top bits
// - Left double result to destination, fill kept
// - Right double shift fills from fill low bits
// - Right double result to destination, fill kept
// - Carry is last bit shifted out
// - Sign, zero, parity from result; aux undefined
// - Overflow on single shift is sign change
// - Logical right shift clears top, carry low
// - Logical right count uses low five bits
// - Logical right overflow is original top bit
// - Logical right flags from result
// - Decode byte logical right forms, 3/4 2/4 clocks
// - Decode word/doubleword logical right forms
// - Decode right double shift forms
// - Decode left double shift forms
// - Protected mode memory faults 13 12 14 17
// - Real mode fault beyond 0FFFFh
module dsu_shift_unit (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  function automatic dsu_pkg::dsu_dec_t dsu_decode(input logic [31:0] c);
    dsu_pkg::dsu_dec_t d;
    logic              mem;
    d     = '{op: dsu_pkg::DSU_OP_NONE, width: 6'h20, csrc: dsu_pkg::DSU_CS_ONE,
              lat: `DSU_LAT_CNT_REG};
    mem   = c[`DSU_CTRL_MEM];
    d.width = c[`DSU_CTRL_SIZE32] ? 6'h20 : 6'h10;
    if (c[`DSU_CTRL_ESC]) begin
      case (c[`DSU_CTRL_OPC_HI:0])
        `DSU_OPC_DL_IMM: begin
          d.op = dsu_pkg::DSU_OP_DLEFT;
          d.csrc = dsu_pkg::DSU_CS_IMM;
        end
        `DSU_OPC_DL_LOW: begin
          d.op = dsu_pkg::DSU_OP_DLEFT;
          d.csrc = dsu_pkg::DSU_CS_LOW;
        end
        `DSU_OPC_DR_IMM: begin
          d.op = dsu_pkg::DSU_OP_DRIGHT;
          d.csrc = dsu_pkg::DSU_CS_IMM;
        end
        `DSU_OPC_DR_LOW: begin
          d.op = dsu_pkg::DSU_OP_DRIGHT;
          d.csrc = dsu_pkg::DSU_CS_LOW;
        end
        default: d.op = dsu_pkg::DSU_OP_NONE;
      endcase
      if (d.csrc == dsu_pkg::DSU_CS_IMM) begin
        d.lat = mem ? `DSU_LAT_DBL_IMM_MEM : `DSU_LAT_IMM_REG;
      end else begin
        d.lat = mem ? `DSU_LAT_CNT_MEM : `DSU_LAT_CNT_REG;
      end
    end else if (c[`DSU_CTRL_REG_HI:`DSU_CTRL_REG_LO] == `DSU_REG_LSR) begin
      d.op = dsu_pkg::DSU_OP_LSR;
      case (c[`DSU_CTRL_OPC_HI:0])
        `DSU_OPC_B_ONE: d.width = 6'h08;
        `DSU_OPC_B_LOW: begin
          d.width = 6'h08;
          d.csrc = dsu_pkg::DSU_CS_LOW;
        end
        `DSU_OPC_B_IMM: begin
          d.width = 6'h08;
          d.csrc = dsu_pkg::DSU_CS_IMM;
        end
        `DSU_OPC_V_ONE: d.csrc = dsu_pkg::DSU_CS_ONE;
        `DSU_OPC_V_LOW: d.csrc = dsu_pkg::DSU_CS_LOW;
        `DSU_OPC_V_IMM: d.csrc = dsu_pkg::DSU_CS_IMM;
        default:        d.op = dsu_pkg::DSU_OP_NONE;
      endcase
      if (d.csrc == dsu_pkg::DSU_CS_IMM) begin
        d.lat = mem ? `DSU_LAT_LSR_IMM_MEM : `DSU_LAT_IMM_REG;
      end else begin
        d.lat = mem ? `DSU_LAT_CNT_MEM : `DSU_LAT_CNT_REG;
      end
    end
    return d;
  endfunction : dsu_decode

  function automatic logic dsu_msb(input logic [31:0] v, input logic [5:0] w);
    logic r;
    case (w)
      6'h08:   r = v[7];
      6'h10:   r = v[15];
      default: r = v[31];
    endcase
    return r;
  endfunction : dsu_msb

  function automatic logic [31:0] dsu_mask(input logic [31:0] v, input logic [5:0] w);
    logic [31:0] r;
    case (w)
      6'h08:   r = {24'h000000, v[7:0]};
      6'h10:   r = {16'h0000, v[15:0]};
      default: r = v;
    endcase
    return r;
  endfunction : dsu_mask

  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  logic [31:0]            ctrl;
  logic [31:0]            dest;
  logic [31:0]            fill;
  logic [7:0]             imm;
  logic [7:0]             cnt_low;
  logic [31:0]            addr;
  logic [11:0]            flags;
  logic                   done;
  logic                   bad_op;
  logic                   exc_valid;
  logic [4:0]             exc_vec;
  dsu_pkg::dsu_state_t    state;
  dsu_pkg::dsu_op_t       op_q;
  logic [5:0]             w_q;
  logic [4:0]             n_q;
  logic [31:0]            a_q;
  logic [31:0]            b_q;
  logic [31:0]            sctrl_q;
  logic [31:0]            saddr_q;
  logic [2:0]             cyc_q;
  logic                   dp_wr;
  logic [7:0]             dp_addr;

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  logic        ap_take;
  logic        wr_en;
  logic [31:0] rd_mux;

  assign ap_take   = hsel && htrans[1] && hready;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign wr_en     = dp_wr && (state == dsu_pkg::DSU_ST_IDLE);

  always_comb begin
    case (haddr[7:0])
      `DSU_OFF_CTRL:    rd_mux = ctrl;
      `DSU_OFF_DEST:    rd_mux = dest;
      `DSU_OFF_FILL:    rd_mux = fill;
      `DSU_OFF_IMM:     rd_mux = {24'h000000, imm};
      `DSU_OFF_CNT_LOW: rd_mux = {24'h000000, cnt_low};
      `DSU_OFF_ADDR:    rd_mux = addr;
      `DSU_OFF_STATUS:  rd_mux = {19'h00000, exc_vec, 4'h0, bad_op, exc_valid, done,
                                  state == dsu_pkg::DSU_ST_EXEC};
      `DSU_OFF_FLAGS:   rd_mux = {20'h00000, flags};
      default:          rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      dp_wr   <= 1'b0;
      dp_addr <= 8'h00;
      hrdata  <= 32'h00000000;
    end else begin
      dp_wr   <= ap_take && hwrite;
      dp_addr <= haddr[7:0];
      if (ap_take && !hwrite) begin
        hrdata <= rd_mux;
      end
    end
  end

  // Operand and control registers, locked while busy
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl    <= 32'h00000000;
      fill    <= 32'h00000000;
      imm     <= 8'h00;
      cnt_low <= 8'h00;
      addr    <= 32'h00000000;
    end else if (wr_en) begin
      case (dp_addr)
        `DSU_OFF_CTRL:    ctrl <= hwdata & `DSU_CTRL_MASK;
        `DSU_OFF_FILL:    fill <= hwdata;
        `DSU_OFF_IMM:     imm <= hwdata[7:0];
        `DSU_OFF_CNT_LOW: cnt_low <= hwdata[7:0];
        `DSU_OFF_ADDR:    addr <= hwdata;
        default:          ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Start and snapshot
  // ----------------------------------------------------------------
  dsu_pkg::dsu_dec_t dec;
  logic              go;
  logic [7:0]        cnt_raw;

  assign dec = dsu_decode(ctrl);
  assign go  = wr_en && (dp_addr == `DSU_OFF_GO) && hwdata[0];

  always_comb begin
    case (dec.csrc)
      dsu_pkg::DSU_CS_LOW: cnt_raw = cnt_low;
      dsu_pkg::DSU_CS_IMM: cnt_raw = imm;
      default:             cnt_raw = 8'h01;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      op_q    <= dsu_pkg::DSU_OP_NONE;
      w_q     <= 6'h20;
      n_q     <= 5'h00;
      a_q     <= 32'h00000000;
      b_q     <= 32'h00000000;
      sctrl_q <= 32'h00000000;
      saddr_q <= 32'h00000000;
    end else if (go) begin
      op_q    <= dec.op;
      w_q     <= dec.width;
      n_q     <= cnt_raw[4:0];
      a_q     <= dsu_mask(dest, dec.width);
      b_q     <= dsu_mask(fill, dec.width);
      sctrl_q <= ctrl;
      saddr_q <= addr;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  logic finish;

  assign finish = (state == dsu_pkg::DSU_ST_EXEC) && (cyc_q == 3'h0);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= dsu_pkg::DSU_ST_IDLE;
      cyc_q <= 3'h0;
    end else begin
      case (state)
        dsu_pkg::DSU_ST_IDLE: begin
          if (go && dec.op != dsu_pkg::DSU_OP_NONE) begin
            state <= dsu_pkg::DSU_ST_EXEC;
            cyc_q <= dec.lat - 3'h1;
          end
        end
        dsu_pkg::DSU_ST_EXEC: begin
          if (cyc_q == 3'h0) begin
            state <= dsu_pkg::DSU_ST_IDLE;
          end else begin
            cyc_q <= cyc_q - 3'h1;
          end
        end
        default: state <= dsu_pkg::DSU_ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Datapath
  // ----------------------------------------------------------------
  logic [64:0] lft;
  logic [64:0] rgt;
  logic [63:0] rsrc;
  logic [31:0] res;
  logic        carry;

  always_comb begin
    // Fill enters at bit 0 from fill top
    lft  = (({33'h000000000, a_q} << (7'h40 - {1'b0, w_q})) |
            ({33'h000000000, b_q} << (7'h40 - {w_q, 1'b0}))) << n_q;
    // Fill enters at the top, zero for logical
    rsrc = {32'h00000000, a_q};
    if (op_q == dsu_pkg::DSU_OP_DRIGHT) begin
      rsrc = rsrc | ({32'h00000000, b_q} << w_q);
    end
    rgt = {rsrc, 1'b0} >> n_q;
    // Oversized counts fall through the same shifter
    if (op_q == dsu_pkg::DSU_OP_DLEFT) begin
      res   = lft[63:32] >> (6'h20 - w_q);
      carry = lft[64];
    end else begin
      res   = dsu_mask(rgt[32:1], w_q);
      carry = rgt[0];
    end
  end

  // ----------------------------------------------------------------
  // Memory operand faults
  // ----------------------------------------------------------------
  logic       exc_hit;
  logic [4:0] exc_code;
  logic [32:0] ea_end;
  logic       misalign;
  logic       user_check;

  always_comb begin
    ea_end     = {1'b0, saddr_q} + {27'h0000000, w_q[5:3]} - 33'h000000001;
    misalign   = |(saddr_q[1:0] & (w_q[4:3] | {w_q[5], 1'b0}));
    user_check = (sctrl_q[`DSU_CTRL_CPL_HI:`DSU_CTRL_CPL_LO] == `DSU_CPL_USER) &&
                 sctrl_q[`DSU_CTRL_ALIGN_EN] && misalign;
    exc_hit    = 1'b0;
    exc_code   = `DSU_VEC_GP;
    if (sctrl_q[`DSU_CTRL_MEM]) begin
      case (dsu_pkg::dsu_mode_t'(sctrl_q[`DSU_CTRL_MODE_HI:`DSU_CTRL_MODE_LO]))
        dsu_pkg::DSU_MODE_PROT: begin
          if (sctrl_q[`DSU_CTRL_STACK] && !sctrl_q[`DSU_CTRL_LEGAL]) begin
            exc_hit  = 1'b1;
            exc_code = `DSU_VEC_SS;
          end else if (!sctrl_q[`DSU_CTRL_WRITABLE] || !sctrl_q[`DSU_CTRL_LEGAL]) begin
            exc_hit  = 1'b1;
          end else if (!sctrl_q[`DSU_CTRL_PRESENT]) begin
            exc_hit  = 1'b1;
            exc_code = `DSU_VEC_PAGE;
          end else if (user_check) begin
            exc_hit  = 1'b1;
            exc_code = `DSU_VEC_ALIGN;
          end
        end
        dsu_pkg::DSU_MODE_REAL: exc_hit = (ea_end > `DSU_REAL_LIMIT);
        dsu_pkg::DSU_MODE_V86: begin
          if (ea_end > `DSU_REAL_LIMIT) begin
            exc_hit  = 1'b1;
          end else if (!sctrl_q[`DSU_CTRL_PRESENT]) begin
            exc_hit  = 1'b1;
            exc_code = `DSU_VEC_PAGE;
          end else if (user_check) begin
            exc_hit  = 1'b1;
            exc_code = `DSU_VEC_ALIGN;
          end
        end
        default: exc_hit = 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Write-back, flags and status
  // ----------------------------------------------------------------
  logic        commit;
  logic [11:0] next_flags;

  assign commit = finish && !exc_hit && (n_q != 5'h00);

  always_comb begin
    next_flags = flags;
    next_flags[`DSU_FLAG_CARRY]  = carry;
    // Result flags, aux left as it was
    next_flags[`DSU_FLAG_PARITY] = ~^res[7:0];
    next_flags[`DSU_FLAG_ZERO]   = (res == 32'h00000000);
    next_flags[`DSU_FLAG_SIGN]   = dsu_msb(res, w_q);
    if (op_q == dsu_pkg::DSU_OP_LSR) begin
      next_flags[`DSU_FLAG_OVER] = dsu_msb(a_q, w_q);
    end else if (n_q == 5'h01) begin
      next_flags[`DSU_FLAG_OVER] = dsu_msb(res, w_q) ^ dsu_msb(a_q, w_q);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      dest  <= 32'h00000000;
      flags <= `DSU_FLAGS_RESET;
    end else if (commit) begin
      // Result goes to the destination only
      dest  <= res;
      flags <= next_flags;
    end else if (wr_en && dp_addr == `DSU_OFF_DEST) begin
      dest  <= hwdata;
    end else if (wr_en && dp_addr == `DSU_OFF_FLAGS) begin
      flags <= (hwdata[11:0] & `DSU_FLAGS_MASK) | `DSU_FLAGS_RESET;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      done      <= 1'b0;
      bad_op    <= 1'b0;
      exc_valid <= 1'b0;
      exc_vec   <= 5'h00;
    end else if (go) begin
      done      <= (dec.op == dsu_pkg::DSU_OP_NONE);
      bad_op    <= (dec.op == dsu_pkg::DSU_OP_NONE);
      exc_valid <= 1'b0;
      exc_vec   <= 5'h00;
    end else if (finish) begin
      done      <= 1'b1;
      exc_valid <= exc_hit;
      exc_vec   <= exc_hit ? exc_code : 5'h00;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking dsu_cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  a_zero_count_hold: assert property (finish && n_q == 5'h00 |=> $stable(dest) && $stable(flags))
    else $error("zero count changed state");
  a_dleft_fill: assert property (commit && op_q == dsu_pkg::DSU_OP_DLEFT && w_q == 6'h20 |=>
    dest == (($past(a_q) << $past(n_q)) | ($past(b_q) >> (6'h20 - {1'b0, $past(n_q)}))))
    else $error("left double result wrong");
  a_fill_kept: assert property (finish |=> $stable(fill))
    else $error("fill register altered");
  a_dright_carry: assert property (commit && op_q == dsu_pkg::DSU_OP_DRIGHT && {1'b0, n_q} < w_q
    |=> flags[`DSU_FLAG_CARRY] == $past(a_q[n_q - 5'h01]))
    else $error("right double carry wrong");
  a_zero_flag: assert property (commit |=> flags[`DSU_FLAG_ZERO] == (dest == 32'h00000000))
    else $error("zero flag mismatch");
  a_over_single: assert property (commit && op_q != dsu_pkg::DSU_OP_LSR && n_q == 5'h01 |=>
    flags[`DSU_FLAG_OVER] == (dsu_msb(dest, $past(w_q)) ^ dsu_msb($past(a_q), $past(w_q))))
    else $error("single shift overflow wrong");
  a_lsr_top_clear: assert property (commit && op_q == dsu_pkg::DSU_OP_LSR |=>
    dsu_msb(dest, $past(w_q)) == 1'b0 && dest == ($past(a_q) >> $past(n_q)))
    else $error("logical right result wrong");
  a_lsr_over: assert property (commit && op_q == dsu_pkg::DSU_OP_LSR |=>
    flags[`DSU_FLAG_OVER] == dsu_msb($past(a_q), $past(w_q)))
    else $error("logical right overflow wrong");
  a_exec_clocks: assert property (go && dec.op != dsu_pkg::DSU_OP_NONE && dec.lat == 3'h3
    |=> (state == dsu_pkg::DSU_ST_EXEC) [*3] ##1 state == dsu_pkg::DSU_ST_IDLE)
    else $error("three clock form wrong length");
  a_real_limit: assert property (finish && sctrl_q[`DSU_CTRL_MEM] &&
    sctrl_q[`DSU_CTRL_MODE_HI:`DSU_CTRL_MODE_LO] == 2'h0 && ea_end > `DSU_REAL_LIMIT
    |=> exc_valid && exc_vec == `DSU_VEC_GP && $stable(dest))
    else $error("real mode limit fault missing");
  a_prot_write: assert property (finish && sctrl_q[`DSU_CTRL_MEM] &&
    sctrl_q[`DSU_CTRL_MODE_HI:`DSU_CTRL_MODE_LO] == 2'h1 && !sctrl_q[`DSU_CTRL_WRITABLE] &&
    !sctrl_q[`DSU_CTRL_STACK] |=> exc_valid && exc_vec == `DSU_VEC_GP)
    else $error("protected write fault missing");

endmodule : dsu_shift_unit
`default_nettype wire

// ==== verification/dsu_bus_master.sv ====
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// Single-word AHB-Lite master
// ----------------------------------------
module dsu_bus_master (
  input  wire logic        ref_clk,
  input  wire logic        hreadyout,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata
);
  initial begin
    hsel = 1'b1;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end

  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] q);
    @(posedge ref_clk);
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= w ? d : ~hwdata;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : xfer
endmodule : dsu_bus_master
`default_nettype wire

// ==== verification/testbench.sv ====
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic        ref_clk;
  logic        rst;
  logic        hsel;
  logic        hwrite;
  logic        hreadyout;
  logic        hresp;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [31:0] res;
  logic [31:0] fl;
  logic [31:0] st;
  logic [31:0] q;
  int          bad_count;
  int          checked;
  int          cycles;

  dsu_shift_unit i_dut (
    .ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata)
  );
  dsu_bus_master i_bus (
    .ref_clk(ref_clk), .hreadyout(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata)
  );

  always #2 ref_clk = ~ref_clk;

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task wrap_up;
    $display("bad_count=%0d checked=%0d", bad_count, checked);
    if (bad_count == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : wrap_up

  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      wrap_up();
    end
  end

  task run_op(input logic [31:0] c, input logic [31:0] dv, input logic [31:0] fv,
              input logic [7:0] n, input logic [31:0] a);
    int k;
    i_bus.xfer(1'b1, 8'h00, c, q);
    i_bus.xfer(1'b1, 8'h04, dv, q);
    i_bus.xfer(1'b1, 8'h08, fv, q);
    i_bus.xfer(1'b1, 8'h0c, {24'h0, n}, q);
    i_bus.xfer(1'b1, 8'h10, {24'h0, n}, q);
    i_bus.xfer(1'b1, 8'h14, a, q);
    i_bus.xfer(1'b1, 8'h18, 32'h1, q);
    st = 32'h0;
    for (k = 0; k < 50 && st[1] !== 1'b1; k++) i_bus.xfer(1'b0, 8'h1c, 32'h0, st);
    i_bus.xfer(1'b0, 8'h04, 32'h0, res);
    i_bus.xfer(1'b0, 8'h20, 32'h0, fl);
  endtask : run_op

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_reset;
    i_bus.xfer(1'b0, 8'h20, 32'h0, q);
    chk(q, 32'h002);
    chk({31'h0, hresp}, 32'h0);
    i_bus.xfer(1'b1, 8'h24, 32'hffff, q);
    i_bus.xfer(1'b0, 8'h24, 32'h0, q);
    chk(q, 32'h0);
  endtask : t_reset

  task t_dleft;
    logic [31:0] c [2];
    logic [31:0] r [2];
    logic [31:0] f [2];
    c = '{32'h11a4, 32'h01a5};
    r = '{32'h2345678a, 32'h0000678e};
    f = '{32'h01, 32'h05};
    foreach (c[i]) begin
      run_op(c[i], 32'h12345678, 32'habcdef01, 8'h24, 0);
      chk(res, r[i]);
      chk(fl & 32'hc5, f[i]);
      i_bus.xfer(1'b0, 8'h08, 32'h0, q);
      chk(q, 32'habcdef01);
    end
  endtask : t_dleft

  task t_dright;
    logic [7:0] opc [2];
    opc = '{8'hac, 8'had};
    foreach (opc[i]) begin
      run_op({24'h1, opc[i]}, 32'h0001, 32'h0001, 8'h21, 0);
      chk(res, 32'h8000);
      chk(fl & 32'h8c5, 32'h885);
    end
  endtask : t_dright

  task t_lsr;
    logic [7:0] opc [6];
    opc = '{8'hd0, 8'hd2, 8'hc0, 8'hd1, 8'hd3, 8'hc1};
    foreach (opc[i]) begin
      run_op(32'h1a00 | {24'h0, opc[i]}, 32'h80000081, 0, 8'h21, 0);
      chk(res, i < 3 ? 32'h40 : 32'h40000040);
      chk(fl & 32'h8c5, 32'h801);
    end
  endtask : t_lsr

  task t_zero;
    i_bus.xfer(1'b1, 8'h20, 32'h0, q);
    run_op(32'h11a4, 32'h55, 32'hffffffff, 8'h20, 0);
    chk(res, 32'h55);
    chk(fl, 32'h002);
    run_op(32'h0, 32'h77, 32'h0, 8'h01, 0);
    chk(st & 32'hf, 32'ha);
    chk(res, 32'h77);
  endtask : t_zero

  task t_fault;
    logic [31:0] c [5];
    logic [31:0] v [5];
    c = '{32'h2861a4, 32'h3561a4, 32'h31a4, 32'ha1a4, 32'h6f71a4};
    v = '{32'h0d04, 32'h0c04, 32'h0d04, 32'h0e04, 32'h1104};
    foreach (c[i]) begin
      run_op(c[i], 32'h12345678, 32'h1, 8'h04, 32'hfffe);
      chk(st & 32'h1f04, v[i]);
      chk(res, 32'h12345678);
    end
  endtask : t_fault

  initial begin
    ref_clk = 1'b0;
    rst = 1'b1;
    bad_count = 0;
    checked = 0;
    cycles = 0;
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    t_reset();
    t_dleft();
    t_dright();
    t_lsr();
    t_zero();
    t_fault();
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
